// file: verilog/pfs_pkg.sv
// Package for the port 0 pad configuration and function select block.
// Assumes a single 250 MHz system clock and an Avalon-MM register slave.
package pfs_pkg;
  localparam int NPIN = 6;
  // Word offsets; byte address is four times the index
  localparam logic [15:0] DATA_IDX = 16'hF210;
  localparam logic [15:0] DIR_IDX = 16'hF211;
  localparam logic [15:0] CTRL_IDX = 16'hF212;
  localparam logic [15:0] FSEL_IDX = 16'hF214;
  localparam int ADDR_W = 18;
  localparam logic [5:0] RST6 = 6'h00;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam int HI_LSB = 8;
  // Function codes
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  localparam logic [1:0] FN_ALT3 = 2'h3;
  // Control pair codes
  localparam logic [1:0] PC_HIZ = 2'h0;
  localparam logic [1:0] PC_PCH = 2'h1;
  localparam logic [1:0] PC_NCH = 2'h2;
  localparam logic [1:0] PC_CMOS = 2'h3;

  // Outgoing signals of the attached peripherals
  typedef struct packed {
    logic sync_serial_data_out;
    logic sync_serial_clock_out;
    logic sync_serial_clock_oe;
    logic uart_transmit_line;
    logic timer_output_0;
    logic timer_output_1;
    logic rc_osc_monitor;
  } pfs_periph_out_t;

  // Pin-side signals routed to peripherals
  typedef struct packed {
    logic rc_wave_input;
    logic sync_serial_data_in;
    logic sync_serial_clock_in;
    logic uart_receive_line;
    logic [5:0] ext_int;
  } pfs_periph_in_t;

  // Peripheral-side reset: receive line idles high
  localparam pfs_periph_in_t PIN_IN_RST = '{rc_wave_input: 1'b0,
    sync_serial_data_in: 1'b0, sync_serial_clock_in: 1'b0,
    uart_receive_line: 1'b1, ext_int: 6'h00};

  // Per-pin pad controls
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pull_up;
    logic [5:0] pull_down;
    logic [5:0] analog;
  } pfs_pad_t;
endpackage : pfs_pkg

// file: verilog/pfs_port0.sv
// Port 0 pad configuration, data path and function routing for six pins.
// Assumes pins arrive asynchronously; peripherals run on i_clk.
// Functional notes
// - Output mode pair: 00 hi-Z, 01 P open-drain, 10 N open-drain, 11 CMOS.
// - Input mode pair: 00 hi-Z, 01 pull-down, 10 pull-up, 11 hi-Z.
// - Direction 0 uses output meaning, direction 1 input meaning; pin 2 at code 10 takes input meaning while sync_serial_clock_oe is low.
// - Six pins each have own control pair and function field.
// - Function select register at F214, 16 bits, byte/word, reset zero.
// - Pin n function code is bit n+8 high, bit n low.
// - Code 00 is general I/O plus external interrupt.
// - Pin 0: 01 RC wave in, 10 serial data out, 11 UART rx.
// - Pin 1: 01 RC ref capacitor, 10 serial data in, 11 UART tx.
// - Pin 2: 01 RC sensor, 10 serial clock, 11 timer out 0.
// - Pin 3: 01 RC ref resistor, 11 timer out 1, 10 prohibited.
// - Pin 4: 01 RC sensor resistor; 10 and 11 prohibited.
// - Pin 5: 01 RC monitor output; 10 and 11 prohibited.
// - Prohibited output: hi-Z or P drive float, N or CMOS drive low.
// - Control register at F212, low bits 5:0, high bits 13:8.
// - Direction 0 output, 1 input, resets to output.
// - Data reads give written value for outputs, pin level for inputs.
`timescale 1ns/1ps
module pfs_port0 (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Avalon-MM slave
  input wire logic [pfs_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Pins
  input wire logic [5:0] i_pin,
  output pfs_pkg::pfs_pad_t o_pad,
  // Peripherals
  input wire pfs_pkg::pfs_periph_out_t i_periph,
  output pfs_pkg::pfs_periph_in_t o_periph
);
  import pfs_pkg::*;

  logic [5:0] data_reg;
  logic [5:0] dir_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] fsel_reg;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;
  pfs_pad_t pad_reg;
  pfs_periph_in_t pin_reg;

  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [15:0] wd, input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [1:0] pair(input logic [15:0] r, input int n);
    pair = {r[n+HI_LSB], r[n]};
  endfunction : pair

  // Address decode
  wire [15:0] idx = i_address[ADDR_W-1:2];
  wire hit_data = (idx == DATA_IDX);
  wire hit_dir = (idx == DIR_IDX);
  wire hit_ctrl = (idx == CTRL_IDX);
  wire hit_fsel = (idx == FSEL_IDX);
  // Take a request while waitrequest is high; commit it at the low edge
  wire access = (i_read | i_write) & wait_reg;
  wire wr = i_write & ~wait_reg;
  wire [5:0] pin_lvl = sync2_reg;

  // Data read mixes written value and pin level per direction
  wire [5:0] data_rd = (data_reg & ~dir_reg) | (pin_lvl & dir_reg);
  wire [31:0] rd_mux = hit_data ? {26'h0, data_rd} :
                       hit_dir ? {26'h0, dir_reg} :
                       hit_ctrl ? {16'h0, ctrl_reg} :
                       hit_fsel ? {16'h0, fsel_reg} : 32'h0;

  // Pad and routing decode
  pfs_pad_t pad_next;
  logic [5:0] gp_out;
  logic [5:0] prohib;
  logic [5:0] p_drv;
  logic [5:0] p_oe_ovr;
  always_comb begin
    pad_next = '0;
    gp_out = '0;
    prohib = '0;
    p_drv = '0;
    p_oe_ovr = '0;
    for (int n = 0; n < NPIN; n++) begin
      logic [1:0] fc;
      logic [1:0] pc;
      logic v;
      logic use_p;
      fc = pair(fsel_reg, n);
      pc = pair(ctrl_reg, n);
      use_p = 1'b0;
      v = data_reg[n];
      // Peripheral sources
      unique case (n)
        0: if (fc == FN_ALT2) begin
          use_p = 1'b1;
          v = i_periph.sync_serial_data_out;
        end
        1: if (fc == FN_ALT3) begin
          use_p = 1'b1;
          v = i_periph.uart_transmit_line;
        end
        2: if (fc == FN_ALT2) begin
          use_p = 1'b1;
          v = i_periph.sync_serial_clock_out;
          p_oe_ovr[n] = ~i_periph.sync_serial_clock_oe;
        end else if (fc == FN_ALT3) begin
          use_p = 1'b1;
          v = i_periph.timer_output_0;
        end
        3: if (fc == FN_ALT3) begin
          use_p = 1'b1;
          v = i_periph.timer_output_1;
        end else if (fc == FN_ALT2) begin
          prohib[n] = 1'b1;
        end
        4: prohib[n] = fc[1];
        5: if (fc == FN_ALT1) begin
          use_p = 1'b1;
          v = i_periph.rc_osc_monitor;
        end else begin
          prohib[n] = fc[1];
        end
        default: ;
      endcase
      p_drv[n] = use_p;
      if (prohib[n]) begin
        v = 1'b0;
      end
      gp_out[n] = v;
      pad_next.analog[n] = (fc == FN_ALT1) & ~(n == 5);
      if (!dir_reg[n] && !p_oe_ovr[n]) begin
        pad_next.out[n] = v;
        unique case (pc)
          PC_HIZ: pad_next.oe[n] = 1'b0;
          PC_PCH: pad_next.oe[n] = v & ~prohib[n];
          PC_NCH: pad_next.oe[n] = ~v;
          PC_CMOS: pad_next.oe[n] = 1'b1;
        endcase
      end else begin
        unique case (pc)
          PC_PCH: pad_next.pull_down[n] = 1'b1;
          PC_NCH: pad_next.pull_up[n] = 1'b1;
          default: ;
        endcase
      end
    end
  end

  function automatic logic [5:0] gpio_sel(input logic [15:0] r);
    for (int n = 0; n < NPIN; n++) begin
      gpio_sel[n] = (pair(r, n) == FN_GPIO);
    end
  endfunction : gpio_sel

  // Pin inputs towards peripherals
  pfs_periph_in_t pin_next;
  assign pin_next.rc_wave_input = pin_lvl[0];
  assign pin_next.sync_serial_data_in = (pair(fsel_reg, 1) == FN_ALT2) &
                                        pin_lvl[1];
  assign pin_next.sync_serial_clock_in = (pair(fsel_reg, 2) == FN_ALT2) &
                                         pin_lvl[2];
  assign pin_next.uart_receive_line = (pair(fsel_reg, 0) == FN_ALT3) ?
                                      pin_lvl[0] : 1'b1;
  assign pin_next.ext_int = pin_lvl & gpio_sel(fsel_reg);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      data_reg <= RST6;
      dir_reg <= RST6;
      ctrl_reg <= RST16;
      fsel_reg <= RST16;
      sync1_reg <= RST6;
      sync2_reg <= RST6;
      rdata_reg <= '0;
      wait_reg <= 1'b1;
      pad_reg <= '0;
      pin_reg <= PIN_IN_RST;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
      wait_reg <= ~access;
      pad_reg <= pad_next;
      pin_reg <= pin_next;
      if (access) begin
        rdata_reg <= rd_mux;
      end
      if (wr && hit_data && i_byteenable[0]) begin
        data_reg <= i_writedata[5:0];
      end
      if (wr && hit_dir && i_byteenable[0]) begin
        dir_reg <= i_writedata[5:0];
      end
      if (wr && hit_ctrl) begin
        ctrl_reg <= merge16(ctrl_reg, i_writedata[15:0], i_byteenable[1:0]);
      end
      if (wr && hit_fsel) begin
        fsel_reg <= merge16(fsel_reg, i_writedata[15:0], i_byteenable[1:0]);
      end
    end
  end

  assign o_readdata = rdata_reg;
  assign o_waitrequest = wait_reg;
  assign o_pad = pad_reg;
  assign o_periph = pin_reg;
endmodule : pfs_port0

// file: tb/pfs_port0_properties.sv
// Checker for the port 0 block, watching its ports only.
// Assumes the bind below attaches it to every pfs_port0 instance.
`timescale 1ns/1ps
module pfs_port0_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [5:0] i_pin,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire pfs_pkg::pfs_pad_t o_pad,
  input wire pfs_pkg::pfs_periph_in_t o_periph
);
  import pfs_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_take;
    (i_read || i_write) && o_waitrequest;
  endsequence
  AST_ANSWER: assert property (s_take |=> !o_waitrequest)
    else $error("request not answered");
  AST_ONE_LOW: assert property
    (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low too long");
  AST_IDLE: assert property
    (!i_read && !i_write && o_waitrequest |=> o_waitrequest)
    else $error("answer without request");
  AST_UPPER: assert property
    (!o_waitrequest |-> o_readdata[31:16] == 16'h0000)
    else $error("upper read data set");
  AST_HOLD: assert property
    (o_waitrequest && $past(o_waitrequest) |-> $stable(o_readdata))
    else $error("read data moved");
  AST_PULL_EXCL: assert property
    ((o_pad.pull_up & o_pad.pull_down) == 6'h00)
    else $error("both pulls on");
  AST_PULL_NO_DRIVE: assert property
    (((o_pad.pull_up | o_pad.pull_down) & o_pad.oe) == 6'h00)
    else $error("pull on a driven pin");
  AST_UART_IDLE: assert property
    (o_periph.ext_int[0] |-> o_periph.uart_receive_line)
    else $error("receive line routed with general code");
  AST_EXT_LAG: assert property
    (o_periph.ext_int[1] |-> $past(i_pin[1], 3))
    else $error("interrupt level without pin level");
  AST_PIN5_DIGITAL: assert property (!o_pad.analog[5])
    else $error("pin 5 marked analog");
endmodule : pfs_port0_chk
bind pfs_port0 pfs_port0_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_read(i_read), .i_write(i_write), .i_pin(i_pin),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_pad(o_pad),
  .o_periph(o_periph));

// file: tb/pfs_pin_model.sv
// Board-side model that resolves the six port 0 pin levels.
// Assumes the bench raises i_ext_en only where it drives a pin itself.
`timescale 1ns/1ps
module pfs_pin_model (
  // Clock
  input wire logic i_clk,
  // Pad controls and board drive
  input wire pfs_pkg::pfs_pad_t i_pad,
  input wire logic [5:0] i_ext,
  input wire logic [5:0] i_ext_en,
  // Resolved levels
  output logic [5:0] o_pin
);
  import pfs_pkg::*;
  logic [5:0] float_reg = 6'h15;
  // Undriven, unpulled pins wander every cycle
  always_ff @(posedge i_clk) float_reg <= ~float_reg;
  always_comb begin
    for (int n = 0; n < NPIN; n++) begin
      if (i_pad.oe[n]) o_pin[n] = i_pad.out[n];
      else if (i_ext_en[n]) o_pin[n] = i_ext[n];
      else if (i_pad.pull_up[n]) o_pin[n] = 1'b1;
      else if (i_pad.pull_down[n]) o_pin[n] = 1'b0;
      else o_pin[n] = float_reg[n];
    end
  end
endmodule : pfs_pin_model

// file: tb/tb_top.sv
// Bench: register accesses, pad modes and routing of the port 0 block.
// Assumes the pin model and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  import pfs_pkg::*;
  logic i_clk = 0;
  logic i_reset_n = 0;
  logic rd = 0;
  logic wr = 0;
  logic [17:0] adr = '0;
  logic [3:0] be = '0;
  logic [31:0] wd = '0;
  logic [31:0] rq;
  logic [31:0] rdat;
  logic wq;
  logic [5:0] pin;
  logic [5:0] ext = '0;
  logic [5:0] ext_en = '0;
  pfs_periph_out_t per = '1;
  pfs_periph_in_t pi;
  pfs_pad_t pad;
  wire [17:0] drv = {pad.oe, pad.pull_up, pad.pull_down};
  int miscompares = 0;
  int n_checks = 0;
  logic [5:0] oe_tab [4] = '{6'h00, 6'h0A, 6'h35, 6'h3F};
  logic [15:0] fs_tab [3] = '{16'h003F, 16'h3F00, 16'h3F3F};
  logic [5:0] ex_tab [3] = '{6'h2A, 6'h07, 6'h0E};
  logic [5:0] an_tab [3] = '{6'h1F, 6'h00, 6'h00};
  logic [17:0] pl_tab [4] = '{18'h0, 18'h0003F, 18'h00FC0, 18'h0};
  always #2 i_clk = ~i_clk;
  pfs_port0 DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_address(adr), .i_read(rd), .i_write(wr), .i_byteenable(be),
    .i_writedata(wd), .o_readdata(rq), .o_waitrequest(wq),
    .i_pin(pin), .o_pad(pad), .i_periph(per), .o_periph(pi));
  pfs_pin_model u_pins (.i_clk(i_clk), .i_pad(pad), .i_ext(ext),
    .i_ext_en(ext_en), .o_pin(pin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic acc(input logic w, input logic [15:0] idx,
      input logic [15:0] d, input logic [3:0] b);
    int k;
    @(posedge i_clk);
    adr <= {idx, 2'b00};
    be <= b;
    wd <= {16'h0000, d};
    rd <= !w;
    wr <= w;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (wq === 1'b0) break;
    end
    rdat = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 20) begin
      miscompares++;
      end_sim();
    end
  endtask : acc
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    acc(1'b0, idx, 16'h0000, 4'h3);
    chk(rdat, exp);
  endtask : rdc
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rdc(FSEL_IDX, 32'h0);
    rdc(CTRL_IDX, 32'h0);
    rdc(DIR_IDX, 32'h0);
    rdc(16'hF216, 32'h0);
    chk(32'(pad.oe), 32'h0);
    chk(32'(pi.uart_receive_line), 32'h1);
    $display("done: reset");
    acc(1'b1, DATA_IDX, 16'h000A, 4'h1);
    rdc(DATA_IDX, 32'h0A);
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, CTRL_IDX, {2'b00, {6{m[1]}}, 2'b00, {6{m[0]}}}, 4'h3);
      repeat (2) @(posedge i_clk);
      chk(32'(pad.oe), 32'(oe_tab[m]));
    end
    chk(32'(pad.out), 32'h0A);
    acc(1'b1, FSEL_IDX, 16'h003F, 4'h1);
    acc(1'b1, FSEL_IDX, 16'h3F00, 4'h2);
    rdc(FSEL_IDX, 32'h3F3F);
    for (int f = 0; f < 3; f++) begin
      acc(1'b1, FSEL_IDX, fs_tab[f], 4'h3);
      repeat (2) @(posedge i_clk);
      chk(32'(pad.out[1:0]), 32'(ex_tab[f][1:0]));
      chk(32'(pad.out[3:2]), 32'(ex_tab[f][3:2]));
      chk(32'(pad.out[5:4]), 32'(ex_tab[f][5:4]));
      chk(32'(pad.analog), 32'(an_tab[f]));
    end
    acc(1'b1, DATA_IDX, 16'h003F, 4'h1);
    repeat (2) @(posedge i_clk);
    chk(32'(pad.oe & 6'h30), 32'h30);
    chk(32'(pad.out & 6'h30), 32'h0);
    acc(1'b1, CTRL_IDX, 16'h003F, 4'h3);
    repeat (2) @(posedge i_clk);
    chk(32'(pad.oe & 6'h30), 32'h0);
    chk(32'(pad.out & 6'h30), 32'h0);
    $display("done: output modes and functions");
    acc(1'b1, FSEL_IDX, 16'h0000, 4'h3);
    acc(1'b1, DIR_IDX, 16'h003F, 4'h1);
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, CTRL_IDX, {2'b00, {6{m[1]}}, 2'b00, {6{m[0]}}}, 4'h3);
      repeat (6) @(posedge i_clk);
      chk(32'(drv), 32'(pl_tab[m]));
      if (m == 1 || m == 2) begin
        rdc(DATA_IDX, 32'({6{m == 2}}));
        chk(32'(pi.ext_int), 32'({6{m == 2}}));
      end
    end
    acc(1'b1, FSEL_IDX, 16'h0101, 4'h3);
    ext_en <= 6'h01;
    repeat (6) @(posedge i_clk);
    chk(32'({pi.uart_receive_line, pi.ext_int[0]}), 32'h0);
    chk(32'(pi.rc_wave_input), 32'h0);
    ext <= 6'h06;
    ext_en <= 6'h07;
    acc(1'b1, FSEL_IDX, 16'h0600, 4'h3);
    repeat (6) @(posedge i_clk);
    chk(32'(pi.sync_serial_data_in), 32'h1);
    chk(32'(pi.sync_serial_clock_in), 32'h1);
    chk(32'(pi.ext_int[2:0]), 32'h0);
    per.sync_serial_clock_oe <= 1'b0;
    acc(1'b1, DIR_IDX, 16'h0000, 4'h1);
    repeat (2) @(posedge i_clk);
    chk(32'(pad.oe), 32'h3B);
    per.sync_serial_clock_oe <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(32'(pad.oe), 32'h3F);
    $display("done: input modes and routing");
    end_sim();
  end
endmodule : tb_top
